// ===== rtl/itac_defines.vh
`ifndef ITAC_DEFINES_VH
`define ITAC_DEFINES_VH
`define ITAC_ADDR_W 8
`define ITAC_OFS_CONTROL 8'h00
`define ITAC_OFS_ABORT_CAUSE 8'h80
`define ITAC_OFS_ABORT_CLEAR 8'hA0
`define ITAC_OFS_INT_STATUS 8'hA4
`define ITAC_OFS_INT_MASK 8'hA8
`define ITAC_CTL_MASTER_EN 0
`define ITAC_CTL_WIDE_ADDR 4
`define ITAC_CTL_RESTART_PERMIT 5
`define ITAC_CTL_RESET 6'h21
`define ITAC_CTL_W 6
`define ITAC_AB_ADDR7_UNACKED 0
`define ITAC_AB_WIDE_ADDR1_UNACKED 1
`define ITAC_AB_WIDE_ADDR2_UNACKED 2
`define ITAC_AB_DATA_UNACKED 3
`define ITAC_AB_GCALL_UNACKED 4
`define ITAC_AB_GCALL_READ 5
`define ITAC_AB_HS_CODE_ACKED 6
`define ITAC_AB_START_BYTE_ACKED 7
`define ITAC_AB_HS_NO_RESTART 8
`define ITAC_AB_START_BYTE_NO_RESTART 9
`define ITAC_AB_WIDE_READ_NO_RESTART 10
`define ITAC_AB_MASTER_DISABLED 11
`define ITAC_AB_SLAVE_ARB_LOST 14
`define ITAC_AB_W 15
`define ITAC_AB_FLUSH_LSB 24
`define ITAC_AB_RESET 32'h0000_0000
`define ITAC_INT_ABORT 0
`define ITAC_INT_ARB_LOST 1
`define ITAC_INT_W 2
`define ITAC_INT_MASK_RESET 2'h0
`endif

// ===== rtl/itac_pin_sync.v
module itac_pin_sync #(
  parameter W = 2
) (
  input wire clk_sys, // system clock
  input wire rst, // sync reset, active high
  input wire [W-1:0] pinIn, // raw pins from outside
  output wire [W-1:0] pinLevel, // synchronised level
  output wire [W-1:0] pinRise // one-cycle rising edge
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  reg [W-1:0] prev_q;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk_sys) begin
        if (rst) begin
          meta_q[i] <= 1'b1;
          sync_q[i] <= 1'b1;
          prev_q[i] <= 1'b1;
        end else begin
          meta_q[i] <= pinIn[i];
          sync_q[i] <= meta_q[i];
          prev_q[i] <= sync_q[i];
        end
      end
      assign pinRise[i] = sync_q[i] & ~prev_q[i];
    end
  endgenerate
  assign pinLevel = sync_q;
endmodule // itac_pin_sync

// ===== rtl/itac_sticky_bits.v
module itac_sticky_bits #(
  parameter W = 8
) (
  input wire clk_sys, // system clock
  input wire rst, // sync reset, active high
  input wire [W-1:0] setIn, // per-bit set pulses
  input wire clrIn, // clear all bits
  output wire [W-1:0] bitsOut // held bits
);
  reg [W-1:0] bits_q;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // set wins over a clear in the same cycle
      always @(posedge clk_sys) begin
        if (rst) begin
          bits_q[i] <= 1'b0;
        end else if (setIn[i]) begin
          bits_q[i] <= 1'b1;
        end else if (clrIn) begin
          bits_q[i] <= 1'b0;
        end
      end
    end
  endgenerate
  assign bitsOut = bits_q;
endmodule // itac_sticky_bits

// ===== rtl/itac_abort_cause.v
// Functional notes
// - master op while master disabled sets bit11
// - no restart, wide-address read sets bit10
// - no restart, start byte sets flag
// - no restart, high-speed transfer sets flag
// - acknowledged start byte sets bit7
// - acknowledged high-speed master code sets flag
// - general call followed by read sets flag
// - unacknowledged general call sets bit4
// - master-only data byte not acknowledged flag
// - wide address second byte unacknowledged flag
// - seven-bit address unacknowledged sets flag
// - slave transmitter arbitration loss sets flag
// - top byte keeps fifo level before abort
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`include "itac_defines.vh"
module itac_abort_cause #(
  parameter AW = `ITAC_ADDR_W,
  parameter FW = 8
) (
  input wire clk_sys, // system clock
  input wire rst, // sync reset, active high
  input wire [AW-1:0] regAddr, // register byte address
  input wire [31:0] regWdata, // write data
  input wire regWr, // write strobe
  input wire regRd, // read strobe
  output wire [31:0] regRdata, // read data, cycle after strobe
  output wire irq, // level interrupt
  output wire abortEvent, // transmit abort event held
  output wire masterEnable, // control: master mode enabled
  output wire restartPermit, // control: restart permit bit
  output wire wideAddrMode, // control: 10-bit addressing
  input wire sclPin, // serial clock pin level
  input wire sdaPin, // serial data pin level
  input wire masterOpReq, // engine tries a master operation
  input wire wideReadReq, // engine issues a wide-address read
  input wire startByteReq, // engine tries to send a start byte
  input wire highSpeedReq, // engine tries a high-speed transfer
  input wire startByteAcked, // start byte was acknowledged
  input wire highSpeedCodeAcked, // high-speed master code acked
  input wire generalCallRead, // byte after general call is a read
  input wire generalCallUnacked, // general call got no ack
  input wire dataUnacked, // data byte after acked address nacked
  input wire wideAddr1Unacked, // first wide address byte nacked
  input wire wideAddr2Unacked, // second wide address byte nacked
  input wire addr7Unacked, // seven-bit address nacked
  input wire slaveTxActive, // engine transmits as slave
  input wire slaveSdaRelease, // engine leaves data line high
  input wire [FW-1:0] txFifoLevel // current transmit fifo level
);
  wire [1:0] pinLevel;
  wire [1:0] pinRise;
  wire sclRise;
  wire sdaLevel;
  reg [`ITAC_CTL_W-1:0] control_q;
  reg [`ITAC_INT_W-1:0] intMask_q;
  reg [FW-1:0] flushCount_q;
  reg [FW-1:0] flushCount_d;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  reg irq_q;
  reg abortEvent_q;
  reg arbArmed_q;
  reg [`ITAC_AB_W-1:0] causeNow;
  wire [`ITAC_AB_W-1:0] causeFlags;
  wire [`ITAC_INT_W-1:0] intStatus;
  wire [`ITAC_INT_W-1:0] intSet;
  wire anyCause;
  wire arbLost;
  wire abortClearRd;
  wire intStatusRd;
  wire masterEn;
  wire restartOk;
  wire wideMode;

  function hit;
    input [AW-1:0] addr;
    input [AW-1:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  itac_pin_sync #(
    .W(2)
  ) u_pins (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinIn({sdaPin, sclPin}),
    .pinLevel(pinLevel),
    .pinRise(pinRise)
  );

  assign sclRise = pinRise[0];
  assign sdaLevel = pinLevel[1];

  assign masterEn = control_q[`ITAC_CTL_MASTER_EN];
  assign restartOk = control_q[`ITAC_CTL_RESTART_PERMIT];
  assign wideMode = control_q[`ITAC_CTL_WIDE_ADDR];

  // slave released the data line but sees it low on a clock rise
  assign arbLost = arbArmed_q & sclRise & ~sdaLevel;

  always @(posedge clk_sys) begin
    if (rst) begin
      arbArmed_q <= 1'b0;
    end else begin
      arbArmed_q <= slaveTxActive & slaveSdaRelease;
    end
  end

  always @* begin
    causeNow = {`ITAC_AB_W{1'b0}};
    causeNow[`ITAC_AB_MASTER_DISABLED] = masterOpReq & ~masterEn;
    causeNow[`ITAC_AB_WIDE_READ_NO_RESTART] =
      wideReadReq & wideMode & ~restartOk;
    causeNow[`ITAC_AB_START_BYTE_NO_RESTART] = startByteReq & ~restartOk;
    causeNow[`ITAC_AB_HS_NO_RESTART] = highSpeedReq & ~restartOk;
    causeNow[`ITAC_AB_START_BYTE_ACKED] = startByteAcked & masterEn;
    causeNow[`ITAC_AB_HS_CODE_ACKED] = highSpeedCodeAcked & masterEn;
    causeNow[`ITAC_AB_GCALL_READ] = generalCallRead & masterEn;
    causeNow[`ITAC_AB_GCALL_UNACKED] = generalCallUnacked & masterEn;
    causeNow[`ITAC_AB_DATA_UNACKED] = dataUnacked & masterEn;
    causeNow[`ITAC_AB_WIDE_ADDR1_UNACKED] = wideAddr1Unacked & wideMode;
    causeNow[`ITAC_AB_WIDE_ADDR2_UNACKED] = wideAddr2Unacked & wideMode;
    causeNow[`ITAC_AB_ADDR7_UNACKED] = addr7Unacked & ~wideMode;
    causeNow[`ITAC_AB_SLAVE_ARB_LOST] = arbLost;
  end

  assign anyCause = |causeNow;
  assign abortClearRd = regRd & hit(regAddr, `ITAC_OFS_ABORT_CLEAR);
  assign intStatusRd = regRd & hit(regAddr, `ITAC_OFS_INT_STATUS);

  // flags stay until software clears the abort event
  itac_sticky_bits #(
    .W(`ITAC_AB_W)
  ) u_causes (
    .clk_sys(clk_sys),
    .rst(rst),
    .setIn(causeNow),
    .clrIn(abortClearRd),
    .bitsOut(causeFlags)
  );

  assign intSet[`ITAC_INT_ABORT] = anyCause;
  assign intSet[`ITAC_INT_ARB_LOST] = arbLost;

  itac_sticky_bits #(
    .W(`ITAC_INT_W)
  ) u_int (
    .clk_sys(clk_sys),
    .rst(rst),
    .setIn(intSet),
    .clrIn(intStatusRd),
    .bitsOut(intStatus)
  );

  // fifo level captured on the abort, not after the flush
  always @* begin
    flushCount_d = flushCount_q;
    if (anyCause) begin
      flushCount_d = txFifoLevel;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      flushCount_q <= {FW{1'b0}};
      abortEvent_q <= 1'b0;
    end else begin
      flushCount_q <= flushCount_d;
      if (anyCause) begin
        abortEvent_q <= 1'b1;
      end else if (abortClearRd) begin
        abortEvent_q <= 1'b0;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      control_q <= `ITAC_CTL_RESET;
      intMask_q <= `ITAC_INT_MASK_RESET;
    end else if (regWr) begin
      if (hit(regAddr, `ITAC_OFS_CONTROL)) begin
        control_q <= regWdata[`ITAC_CTL_W-1:0];
      end
      if (hit(regAddr, `ITAC_OFS_INT_MASK)) begin
        intMask_q <= regWdata[`ITAC_INT_W-1:0];
      end
    end
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    if (regRd) begin
      case (1'b1)
        hit(regAddr, `ITAC_OFS_CONTROL): begin
          rdata_d[`ITAC_CTL_W-1:0] = control_q;
        end
        hit(regAddr, `ITAC_OFS_ABORT_CAUSE): begin
          rdata_d[`ITAC_AB_W-1:0] = causeFlags;
          rdata_d[`ITAC_AB_FLUSH_LSB+FW-1:`ITAC_AB_FLUSH_LSB] = flushCount_q;
        end
        hit(regAddr, `ITAC_OFS_ABORT_CLEAR): begin
          rdata_d[0] = abortEvent_q;
        end
        hit(regAddr, `ITAC_OFS_INT_STATUS): begin
          rdata_d[`ITAC_INT_W-1:0] = intStatus;
        end
        hit(regAddr, `ITAC_OFS_INT_MASK): begin
          rdata_d[`ITAC_INT_W-1:0] = intMask_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      irq_q <= |(intStatus & intMask_q);
    end
  end

  assign regRdata = rdata_q;
  assign irq = irq_q;
  assign abortEvent = abortEvent_q;
  // control outputs are register bits directly
  assign masterEnable = control_q[`ITAC_CTL_MASTER_EN];
  assign restartPermit = control_q[`ITAC_CTL_RESTART_PERMIT];
  assign wideAddrMode = control_q[`ITAC_CTL_WIDE_ADDR];
endmodule // itac_abort_cause

// ===== sim/itac_bus_model.sv
module itac_bus_model (
  output logic scl, // far master clock
  output logic sda, // far master data
  input wire logic go // start one contested frame
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // wins arbitration: data held low while clock pulses, then driven high again
  always @(posedge go) begin
    sda = 1'b0;
    repeat (2) begin
      #62.5 scl = 1'b0;
      #62.5 scl = 1'b1;
    end
    #62.5 sda = 1'b1;
  end
endmodule // itac_bus_model

// ===== sim/itac_abort_cause_props.sv
module itac_abort_cause_props #(parameter AW = 8) (
  input wire clk_sys, rst, regRd, abortEvent, masterEnable,
  input wire restartPermit, wideAddrMode, slaveTxActive,
  input wire masterOpReq, wideReadReq, startByteReq, highSpeedReq,
  input wire startByteAcked, highSpeedCodeAcked, generalCallRead,
  input wire generalCallUnacked, dataUnacked, wideAddr1Unacked,
  input wire wideAddr2Unacked, addr7Unacked,
  input wire [AW-1:0] regAddr,
  input wire [31:0] regRdata
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire anyCause = masterOpReq | wideReadReq | startByteReq | highSpeedReq
    | startByteAcked | highSpeedCodeAcked | generalCallRead | generalCallUnacked
    | dataUnacked | wideAddr1Unacked | wideAddr2Unacked | addr7Unacked;
  sequence s_quiet;
    !slaveTxActive [*5];
  endsequence
  sequence s_clr_rd;
    regRd && regAddr == 8'hA0 && !anyCause;
  endsequence
  a_master_dis: assert property (masterOpReq && !masterEnable |=> abortEvent)
    else $error("master-disabled abort missed");
  a_wide_rd: assert property (wideReadReq && wideAddrMode && !restartPermit |=> abortEvent)
    else $error("wide read abort missed");
  a_sbyte_norst: assert property (startByteReq && !restartPermit |=> abortEvent)
    else $error("start byte abort missed");
  a_hs_norst: assert property (highSpeedReq && !restartPermit |=> abortEvent)
    else $error("high speed abort missed");
  a_master_nack: assert property (masterEnable && (startByteAcked || highSpeedCodeAcked
    || generalCallRead || generalCallUnacked || dataUnacked) |=> abortEvent)
    else $error("master cause abort missed");
  a_addr_nack: assert property ((wideAddrMode && wideAddr2Unacked)
    || (!wideAddrMode && addr7Unacked) |=> abortEvent)
    else $error("address nack abort missed");
  a_event_hold: assert property (abortEvent && !(regRd && regAddr == 8'hA0) |=> abortEvent)
    else $error("abort event dropped");
  a_event_clear: assert property (s_quiet ##0 s_clr_rd |=> !abortEvent)
    else $error("abort event not cleared");
  a_rdata_idle: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data not idle");
endmodule // itac_abort_cause_props
bind itac_abort_cause itac_abort_cause_props #(.AW(AW)) u_props (.clk_sys(clk_sys),
  .rst(rst), .regRd(regRd), .abortEvent(abortEvent), .masterEnable(masterEnable),
  .restartPermit(restartPermit), .wideAddrMode(wideAddrMode),
  .slaveTxActive(slaveTxActive), .masterOpReq(masterOpReq), .wideReadReq(wideReadReq),
  .startByteReq(startByteReq), .highSpeedReq(highSpeedReq),
  .startByteAcked(startByteAcked), .highSpeedCodeAcked(highSpeedCodeAcked),
  .generalCallRead(generalCallRead), .generalCallUnacked(generalCallUnacked),
  .dataUnacked(dataUnacked), .wideAddr1Unacked(wideAddr1Unacked),
  .wideAddr2Unacked(wideAddr2Unacked), .addr7Unacked(addr7Unacked),
  .regAddr(regAddr), .regRdata(regRdata));

// ===== sim/test_itac_abort_cause.sv
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module test_itac_abort_cause;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, slaveTx = 1'b0, go = 1'b0;
  logic [7:0] regAddr = 8'h00, lvl = 8'h00;
  logic [31:0] regWdata = 32'h0, rdv;
  logic [11:0] pv = 12'h000;
  wire [31:0] regRdata;
  wire irq, abortEvent, masterEnable, restartPermit, wideAddrMode, scl, sda;
  int n_fail = 0, comparisons = 0, seed = 32'hE32B5B1C, i;
  int bitOf[12] = '{11, 10, 9, 8, 7, 6, 5, 4, 3, 1, 2, 0};
  logic [7:0] goodCtl[12] = '{8'h20, 8'h11, 8'h01, 8'h01, 8'h21, 8'h21, 8'h21, 8'h21,
    8'h21, 8'h31, 8'h31, 8'h21};
  logic [7:0] badCtl[12] = '{8'h21, 8'h31, 8'h21, 8'h21, 8'h20, 8'h20, 8'h20, 8'h20,
    8'h20, 8'h21, 8'h21, 8'h31};
  always #5 clk_sys = ~clk_sys;
  itac_bus_model i_far (.scl(scl), .sda(sda), .go(go));
  itac_abort_cause i_dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
    .abortEvent(abortEvent), .masterEnable(masterEnable), .restartPermit(restartPermit),
    .wideAddrMode(wideAddrMode), .sclPin(scl), .sdaPin(sda), .masterOpReq(pv[0]),
    .wideReadReq(pv[1]), .startByteReq(pv[2]), .highSpeedReq(pv[3]),
    .startByteAcked(pv[4]), .highSpeedCodeAcked(pv[5]), .generalCallRead(pv[6]),
    .generalCallUnacked(pv[7]), .dataUnacked(pv[8]), .wideAddr1Unacked(pv[9]),
    .wideAddr2Unacked(pv[10]), .addr7Unacked(pv[11]), .slaveTxActive(slaveTx),
    .slaveSdaRelease(slaveTx), .txFifoLevel(lvl));
  task wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
    @(posedge clk_sys);
  endtask
  // one cause pulse, then event and interrupt level
  task hit(input int k, input logic on, input logic iq);
    pv <= 12'h001 << k;
    @(posedge clk_sys);
    pv <= 12'h000;
    #1 `CHK(abortEvent, on)
    @(posedge clk_sys);
    #1 `CHK(irq, iq)
    @(posedge clk_sys);
  endtask
  task test_done;
    $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    `CHK({irq, abortEvent, regRdata}, 34'h0)
    rd(8'h00, rdv);
    `CHK(rdv, 32'h00000021)
    rd(8'h44, rdv);
    `CHK(rdv, 32'h0)
    wr(8'h80, 32'hFFFFFFFF);
    rd(8'h80, rdv);
    `CHK(rdv, 32'h0)
    wr(8'hA8, 32'h1);
    for (i = 0; i < 12; i++) begin
      lvl <= 8'($random(seed));
      wr(8'h00, {24'h0, badCtl[i]});
      `CHK({masterEnable, wideAddrMode, restartPermit}, {badCtl[i][0], badCtl[i][4], badCtl[i][5]})
      hit(i, 1'b0, 1'b0);
      rd(8'h80, rdv);
      `CHK(rdv[14:0], 15'h0)
      wr(8'h00, {24'h0, goodCtl[i]});
      hit(i, 1'b1, 1'b1);
      rd(8'h80, rdv);
      `CHK(rdv, {lvl, 9'h0, 15'(1 << bitOf[i])})
      rd(8'hA0, rdv);
      `CHK(rdv[0], 1'b1)
      rd(8'hA4, rdv);
      `CHK(rdv[0], 1'b1)
      rd(8'h80, rdv);
      `CHK(rdv[14:0], 15'h0)
    end
    wr(8'h00, 32'h21);
    wr(8'hA8, 32'h0);
    hit(8, 1'b1, 1'b0);
    hit(11, 1'b1, 1'b0);
    rd(8'h80, rdv);
    `CHK(rdv, {lvl, 9'h0, 15'h0009})
    rd(8'hA0, rdv);
    rd(8'hA4, rdv);
    wr(8'hA8, 32'h3);
    slaveTx <= 1'b1;
    go <= 1'b1;
    repeat (40) @(posedge clk_sys);
    #1 `CHK(abortEvent, 1'b1)
    `CHK(irq, 1'b1)
    @(posedge clk_sys);
    rd(8'h80, rdv);
    `CHK(rdv, {lvl, 9'h0, 15'h4000})
    go <= 1'b0;
    slaveTx <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h80, rdv);
    `CHK(rdv, 32'h0)
    `CHK({irq, abortEvent, masterEnable, restartPermit, wideAddrMode}, 5'b00110)
    test_done;
  end
endmodule // test_itac_abort_cause
